// file: rtl/pmx_pkg.sv
package pmx_pkg;

  // register bus geometry
  localparam int PMX_AW = 12;
  localparam int PMX_NPORT = 5;
  localparam logic [2:0] PMX_NFIELD = 3'd5;
  localparam logic [2:0] PMX_NMISC = 3'd3;

  // byte address = {port, field, 2'b00}; port index 0..4 = ports 0,1,3,4,5
  localparam logic [PMX_AW-1:0] PMX_PORT_STRIDE = 12'h020;
  localparam logic [2:0] PMX_FLD_LATCH = 3'd0;
  localparam logic [2:0] PMX_FLD_DIR = 3'd1;
  localparam logic [2:0] PMX_FLD_FSEL = 3'd2;
  localparam logic [2:0] PMX_FLD_CHOICE = 3'd3;
  localparam logic [2:0] PMX_FLD_OD = 3'd4;
  // misc group at 0x0a0
  localparam logic [2:0] PMX_MISC_PORT = 3'd5;
  localparam logic [2:0] PMX_FLD_KEY = 3'd0;
  localparam logic [2:0] PMX_FLD_RISE = 3'd1;
  localparam logic [2:0] PMX_FLD_FALL = 3'd2;

  // variant strap: two-wire bus present
  localparam logic PMX_HAS_TWO_WIRE = 1'b1;

  // implemented pins per port {p5, p4, p3, p1, p0}
  localparam logic [4:0][15:0] PMX_PIN_MASK =
    {16'h003f, 16'h0007, 16'h033f, 16'h0003, 16'h007f};
  // pins that own a function-select bit (port 1 has none)
  localparam logic [4:0][15:0] PMX_FSEL_MASK =
    {16'h003f, 16'h0007,
     (PMX_HAS_TWO_WIRE ? 16'h033f : 16'h003f), 16'h0000, 16'h007f};
  // pins with two peripheral functions
  localparam logic [4:0][15:0] PMX_CHOICE_MASK =
    {16'h003f, 16'h0000, 16'h0028, 16'h0000, 16'h0000};
  // clocked-serial pins where open-drain is ignored under function 1
  localparam logic [4:0][15:0] PMX_OD_IGNORE =
    {16'h0030, 16'h0006, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] PMX_KEY_MASK = 16'h003f;
  localparam logic [15:0] PMX_EDGE_MASK = 16'h007c;

  // reset values
  localparam logic [15:0] PMX_DIR_RST = 16'hffff;
  localparam logic [15:0] PMX_LATCH_RST = 16'h0000;
  localparam logic [15:0] PMX_CTRL_RST = 16'h0000;

  localparam logic [1:0] PMX_RESP_OKAY = 2'b00;
  localparam logic [1:0] PMX_RESP_SLVERR = 2'b10;

  // one port's drive: value and enable per pin
  typedef struct packed {
    logic [15:0] o;
    logic [15:0] oe;
  } pmx_drive_t;

  typedef struct packed {
    logic hit;
    logic [2:0] port;
    logic [2:0] field;
  } pmx_dec_t;

  // register decode, shared by read and write paths
  function automatic pmx_dec_t pmx_decode(input logic [PMX_AW-1:0] a);
    pmx_dec_t d;
    d.port = a[7:5];
    d.field = a[4:2];
    d.hit = (a[11:8] == 4'h0) && (a[1:0] == 2'b00) &&
      (((d.port < 3'(PMX_NPORT)) && (d.field < PMX_NFIELD)) ||
       ((d.port == PMX_MISC_PORT) && (d.field < PMX_NMISC)));
    return d;
  endfunction : pmx_decode

  // byte-lane merge of a 16-bit register
  function automatic logic [15:0] pmx_merge(input logic [15:0] old,
                                             input logic [15:0] wd,
                                             input logic [1:0] strb,
                                             input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}} & mask;
    return (old & ~m) | (wd & m);
  endfunction : pmx_merge

endpackage : pmx_pkg

// file: rtl/pmx_port_mux.sv
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
// Notes on behaviour
// - function-select 1 routes pin to peripheral
// - peripheral mode ignores latch and direction
// - choice bit picks first or second function
// - two-wire pins open-drain only when their open-drain bit is set, variant only
// - serial out/clock ignore open-drain bit under function 1
// - select bits per pin, byte writable
module pmx_port_mux
  import pmx_pkg::*;
(
  input wire logic aclk, // 10 MHz clock
  input wire logic aresetn, // sync reset, low
  input wire logic [PMX_AW-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [PMX_AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [4:0][15:0] pad_in, // pin levels
  output pmx_drive_t [4:0] pad_out, // pin drive and enable
  input wire pmx_drive_t [4:0] periph_fn1, // first function drive
  input wire pmx_drive_t [4:0] periph_fn2, // second function drive
  output logic [4:0][15:0] periph_in1, // pin to first function
  output logic [4:0][15:0] periph_in2, // pin to second function
  output logic [5:0] key_return_input, // key-return levels
  output logic [15:0] rising_edge_select, // port 0 edge enables
  output logic [15:0] falling_edge_select, // port 0 edge enables
  output logic [1:0] analog_output_en // analog pins released
);

  logic [4:0][15:0] port_output_latch_r;
  logic [4:0][15:0] pin_direction_bits_r; // 1 = input
  logic [4:0][15:0] pin_function_select_r;
  logic [4:0][15:0] alt_function_choice_r;
  logic [4:0][15:0] open_drain_select_r;
  logic [15:0] key_return_enable_r;
  logic aw_full_r, w_full_r;
  logic [PMX_AW-1:0] awaddr_r;
  logic [15:0] wdata_r;
  logic [1:0] wstrb_r;
  logic aw_hs, w_hs, wr_commit, ar_hs;
  logic aw_full_nxt, w_full_nxt, bvalid_nxt, rvalid_nxt;
  pmx_dec_t wdec, rdec;
  logic [4:0][15:0] alt_v, choice_v, od_eff, drv_v, drv_en;

  // write channel handshakes, either order
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign wr_commit = aw_full_r & w_full_r;
  assign wdec = pmx_decode(awaddr_r);
  assign aw_full_nxt = wr_commit ? 1'b0 : (aw_full_r | aw_hs);
  assign w_full_nxt = wr_commit ? 1'b0 : (w_full_r | w_hs);
  assign bvalid_nxt = wr_commit | (s_axi_bvalid & ~s_axi_bready);

  // write address/data capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PMX_RESP_OKAY;
    end else begin
      if (aw_hs) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_r <= s_axi_wdata[15:0];
        wstrb_r <= s_axi_wstrb[1:0];
      end
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      s_axi_awready <= ~aw_full_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_full_nxt & ~bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (wr_commit) begin
        s_axi_bresp <= wdec.hit ? PMX_RESP_OKAY : PMX_RESP_SLVERR;
      end
    end
  end

  // control register writes, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_output_latch_r <= {PMX_NPORT{PMX_LATCH_RST}};
      pin_direction_bits_r <= PMX_PIN_MASK & {PMX_NPORT{PMX_DIR_RST}};
      pin_function_select_r <= {PMX_NPORT{PMX_CTRL_RST}};
      alt_function_choice_r <= {PMX_NPORT{PMX_CTRL_RST}};
      open_drain_select_r <= {PMX_NPORT{PMX_CTRL_RST}};
      key_return_enable_r <= PMX_CTRL_RST;
      rising_edge_select <= PMX_CTRL_RST;
      falling_edge_select <= PMX_CTRL_RST;
    end else if (wr_commit && wdec.hit) begin
      if (wdec.port == PMX_MISC_PORT) begin
        unique case (wdec.field)
          PMX_FLD_KEY: key_return_enable_r <= pmx_merge(key_return_enable_r,
            wdata_r, wstrb_r, PMX_KEY_MASK);
          PMX_FLD_RISE: rising_edge_select <= pmx_merge(rising_edge_select,
            wdata_r, wstrb_r, PMX_EDGE_MASK);
          default: falling_edge_select <= pmx_merge(falling_edge_select,
            wdata_r, wstrb_r, PMX_EDGE_MASK);
        endcase
      end else begin
        unique case (wdec.field)
          PMX_FLD_LATCH: port_output_latch_r[wdec.port] <= pmx_merge(
            port_output_latch_r[wdec.port], wdata_r, wstrb_r,
            PMX_PIN_MASK[wdec.port]);
          PMX_FLD_DIR: pin_direction_bits_r[wdec.port] <= pmx_merge(
            pin_direction_bits_r[wdec.port], wdata_r, wstrb_r,
            PMX_PIN_MASK[wdec.port]);
          PMX_FLD_FSEL: pin_function_select_r[wdec.port] <= pmx_merge(
            pin_function_select_r[wdec.port], wdata_r, wstrb_r,
            PMX_FSEL_MASK[wdec.port]);
          PMX_FLD_CHOICE: alt_function_choice_r[wdec.port] <= pmx_merge(
            alt_function_choice_r[wdec.port], wdata_r, wstrb_r,
            PMX_CHOICE_MASK[wdec.port]);
          default: open_drain_select_r[wdec.port] <= pmx_merge(
            open_drain_select_r[wdec.port], wdata_r, wstrb_r,
            PMX_PIN_MASK[wdec.port]);
        endcase
      end
    end
  end

  // read channel: one outstanding read
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign rdec = pmx_decode(s_axi_araddr);
  assign rvalid_nxt = ar_hs | (s_axi_rvalid & ~s_axi_rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PMX_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (ar_hs) begin
        s_axi_rresp <= rdec.hit ? PMX_RESP_OKAY : PMX_RESP_SLVERR;
        s_axi_rdata <= '0;
        if (rdec.hit && rdec.port == PMX_MISC_PORT) begin
          unique case (rdec.field)
            PMX_FLD_KEY: s_axi_rdata[15:0] <= key_return_enable_r;
            PMX_FLD_RISE: s_axi_rdata[15:0] <= rising_edge_select;
            default: s_axi_rdata[15:0] <= falling_edge_select;
          endcase
        end else if (rdec.hit) begin
          unique case (rdec.field)
            // inputs read the pin, outputs read the latch
            PMX_FLD_LATCH: s_axi_rdata[15:0] <=
              PMX_PIN_MASK[rdec.port] &
              ((pin_direction_bits_r[rdec.port] & pad_in[rdec.port]) |
               (~pin_direction_bits_r[rdec.port] &
                port_output_latch_r[rdec.port]));
            PMX_FLD_DIR: s_axi_rdata[15:0] <= pin_direction_bits_r[rdec.port];
            PMX_FLD_FSEL: s_axi_rdata[15:0] <= pin_function_select_r[rdec.port];
            PMX_FLD_CHOICE:
              s_axi_rdata[15:0] <= alt_function_choice_r[rdec.port];
            default: s_axi_rdata[15:0] <= open_drain_select_r[rdec.port];
          endcase
        end
      end
    end
  end

  // per-port steering of drive value and enable
  for (genvar p = 0; p < PMX_NPORT; p++) begin : g_port
    assign alt_v[p] = pin_function_select_r[p] & PMX_FSEL_MASK[p];
    assign choice_v[p] = alt_function_choice_r[p] & alt_v[p];
    assign od_eff[p] = open_drain_select_r[p] &
      ~(alt_v[p] & ~choice_v[p] & PMX_OD_IGNORE[p]);
    // peripheral owns value and enable, latch/dir unused
    assign drv_v[p] = (alt_v[p] & ((choice_v[p] & periph_fn2[p].o) |
      (~choice_v[p] & periph_fn1[p].o))) |
      (~alt_v[p] & port_output_latch_r[p]);
    assign drv_en[p] = PMX_PIN_MASK[p] & ((alt_v[p] &
      ((choice_v[p] & periph_fn2[p].oe) | (~choice_v[p] & periph_fn1[p].oe)))
      | (~alt_v[p] & ~pin_direction_bits_r[p]));
  end

  // registered pads; open-drain only pulls low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_out <= '0;
    end else begin
      for (int p = 0; p < PMX_NPORT; p++) begin
        pad_out[p].o <= drv_v[p] & ~od_eff[p];
        pad_out[p].oe <= drv_en[p] & ~(od_eff[p] & drv_v[p]);
      end
    end
  end

  // pin levels back to peripherals and key-return; analog enables from port 1 direction bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_in1 <= '0;
      periph_in2 <= '0;
      key_return_input <= '0;
      analog_output_en <= '0;
    end else begin
      for (int p = 0; p < PMX_NPORT; p++) begin
        periph_in1[p] <= pad_in[p] & alt_v[p] & ~choice_v[p];
        periph_in2[p] <= pad_in[p] & choice_v[p];
      end
      key_return_input <= pad_in[4][5:0] & key_return_enable_r[5:0] &
        ~alt_v[4][5:0] & pin_direction_bits_r[4][5:0];
      analog_output_en <= pin_direction_bits_r[1][1:0];
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_ALT_ROUTE: assert property (alt_v[0][3] && !od_eff[0][3]
    |=> pad_out[0].o[3] == $past(periph_fn1[0].o[3]))
    else $error("function pin not routed to peripheral");
  AST_IGNORE_PORT: assert property (alt_v[2][0] && !od_eff[2][0]
    |=> pad_out[2].oe[0] == $past(periph_fn1[2].oe[0]))
    else $error("function pin enable follows direction bit");
  AST_CHOICE_TWO: assert property (choice_v[4][0] && !od_eff[4][0]
    |=> pad_out[4].o[0] == $past(periph_fn2[4].o[0]) &&
        pad_out[4].oe[0] == $past(periph_fn2[4].oe[0]))
    else $error("second function not selected");
  AST_SERIAL_OD: assert property (alt_v[3][2] && !choice_v[3][2]
    |=> pad_out[3].oe[2] == $past(periph_fn1[3].oe[2]))
    else $error("serial pin affected by open-drain bit");
  AST_TWO_WIRE: assert property (alt_v[2][8] &&
    open_drain_select_r[2][8]
    |=> !pad_out[2].o[8] && (pad_out[2].oe[8] ==
        ($past(periph_fn1[2].oe[8]) && !$past(periph_fn1[2].o[8]))))
    else $error("two-wire pin not open-drain");
  AST_BYTE_LANE: assert property (wr_commit && wdec.hit &&
    wdec.port == 3'd2 && wdec.field == PMX_FLD_FSEL && wstrb_r == 2'b10
    |=> $stable(pin_function_select_r[2][7:0]))
    else $error("masked byte lane was written");
  AST_PORT_MODE: assert property (!alt_v[0][1] &&
    !pin_direction_bits_r[0][1] && !open_drain_select_r[0][1]
    |=> pad_out[0].oe[1] &&
        pad_out[0].o[1] == $past(port_output_latch_r[0][1]))
    else $error("port-mode output not driven from latch");

  COV_SECOND_FN: cover property (choice_v[4][4] ##1 pad_out[4].oe[4]);
  COV_KEY_RETURN: cover property (key_return_input[0]);
  COV_WRITE: cover property (wr_commit ##1 s_axi_bvalid && s_axi_bready);

endmodule : pmx_port_mux

// file: verification/pmx_periph_model.sv
`timescale 1ns/100ps
// stand-in for the on-chip peripherals and the board pins
module pmx_periph_model
  import pmx_pkg::*;
#(
  parameter logic [15:0] FN1_O = 16'h1e1e,
  parameter logic [15:0] FN1_OE = 16'h0505,
  parameter logic [15:0] FN2_O = 16'h2b2b,
  parameter logic [15:0] FN2_OE = 16'hffff
)(
  input wire pmx_drive_t [4:0] pad_out, // block drive
  input wire logic [15:0] ext_level, // board level on released pins
  output logic [4:0][15:0] pad_in, // resolved pin level
  output pmx_drive_t [4:0] periph_fn1, // first function drive
  output pmx_drive_t [4:0] periph_fn2 // second function drive
);
  // a released pin shows the board level, a driven one the block value
  always_comb begin
    for (int p = 0; p < 5; p++) begin
      pad_in[p] = (pad_out[p].o & pad_out[p].oe) |
        (ext_level & ~pad_out[p].oe);
      periph_fn1[p] = '{o: FN1_O, oe: FN1_OE};
      periph_fn2[p] = '{o: FN2_O, oe: FN2_OE};
    end
  end
endmodule : pmx_periph_model

// file: verification/port_alternate_function_mux_test.sv
`timescale 1ns/100ps
module port_alternate_function_mux_test;
  import pmx_pkg::*;
  localparam logic [15:0] F1O = 16'h1f1e, F1E = 16'h0535;
  localparam logic [15:0] F2O = 16'h2b2b, F2E = 16'hffff;
  localparam logic [15:0] EXT = 16'h5a69;
  localparam logic [1:0] OK = PMX_RESP_OKAY, ER = PMX_RESP_SLVERR;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, ana;
  logic [4:0][15:0] pad_in, pin1, pin2;
  pmx_drive_t [4:0] pad_out, fn1, fn2;
  logic [5:0] key;
  logic [15:0] rise, fall, ext;
  int bad_count, n_compared;

  pmx_port_mux pmx_port_mux_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pad_in(pad_in),
    .pad_out(pad_out), .periph_fn1(fn1), .periph_fn2(fn2),
    .periph_in1(pin1), .periph_in2(pin2), .key_return_input(key),
    .rising_edge_select(rise), .falling_edge_select(fall),
    .analog_output_en(ana));
  pmx_periph_model #(.FN1_O(F1O), .FN1_OE(F1E), .FN2_O(F2O), .FN2_OE(F2E))
    pmx_periph_model_i (.pad_out(pad_out), .ext_level(ext),
    .pad_in(pad_in), .periph_fn1(fn1), .periph_fn2(fn2));

  // free-running bus clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [11:0] ra(input int p, input logic [2:0] f);
    return 12'(p * 32) + {7'h0, f, 2'b00};
  endfunction : ra

  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [15:0] d,
                    input logic [1:0] s, input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0, d};
    wstrb <= {2'b00, s};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) begin
      bad_count++;
      close_out();
    end
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask : wr

  // one read, compared against the expected word and response
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp,
                     input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) begin
      bad_count++;
      close_out();
    end
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    chk($sformatf("rdata at %h", a), rdata, exp);
  endtask : rdc

  // pin drive and peripheral inputs expected from one port's settings
  task automatic pin(input int p, input logic [15:0] m, lat, dir, fs, ch);
    logic [15:0] oe, o, lv, sn;
    repeat (3) @(posedge aclk);
    oe = m & ((~fs & ~dir) | (fs & ~ch & F1E) | (fs & ch & F2E));
    o = oe & ((~fs & lat) | (fs & ~ch & F1O) | (fs & ch & F2O));
    lv = o | (EXT & ~oe);
    sn = pad_out[p].o & pad_out[p].oe;
    chk("drive", {sn, pad_out[p].oe}, {o, oe});
    chk("fn1 in", {16'h0, pin1[p]}, {16'h0, fs & ~ch & lv});
    chk("fn2 in", {16'h0, pin2[p]}, {16'h0, fs & ch & lv});
  endtask : pin

  task automatic t_reset;
    rdc(ra(0, PMX_FLD_DIR), 32'h7f, OK);
    rdc(ra(2, PMX_FLD_FSEL), 32'h0, OK);
    rdc(12'h0b0, 32'h0, ER);
    wr(12'h0b0, 16'hffff, 2'b11, ER);
    pin(3, 16'h7, 16'h0, 16'h7, 16'h0, 16'h0);
    $display("reset test done");
  endtask : t_reset

  task automatic t_port;
    wr(ra(0, PMX_FLD_LATCH), 16'h0055, 2'b11, OK);
    wr(ra(0, PMX_FLD_DIR), 16'h0034, 2'b11, OK);
    pin(0, 16'h7f, 16'h55, 16'h34, 16'h0, 16'h0);
    rdc(ra(0, PMX_FLD_LATCH), 32'h61, OK);
    $display("port mode test done");
  endtask : t_port

  task automatic t_func;
    wr(ra(0, PMX_FLD_FSEL), 16'h000f, 2'b11, OK);
    pin(0, 16'h7f, 16'h55, 16'h34, 16'h0f, 16'h0);
    $display("function select test done");
  endtask : t_func

  task automatic t_choice;
    wr(ra(4, PMX_FLD_FSEL), 16'h003f, 2'b11, OK);
    wr(ra(4, PMX_FLD_CHOICE), 16'h0015, 2'b11, OK);
    pin(4, 16'h3f, 16'h0, 16'h3f, 16'h3f, 16'h15);
    wr(ra(4, PMX_FLD_CHOICE), 16'h002a, 2'b11, OK);
    pin(4, 16'h3f, 16'h0, 16'h3f, 16'h3f, 16'h2a);
    $display("choice test done");
  endtask : t_choice

  task automatic t_serial;
    wr(ra(3, PMX_FLD_OD), 16'h0006, 2'b11, OK);
    wr(ra(3, PMX_FLD_FSEL), 16'h0006, 2'b11, OK);
    pin(3, 16'h7, 16'h0, 16'h7, 16'h6, 16'h0);
    wr(ra(4, PMX_FLD_CHOICE), 16'h0000, 2'b11, OK);
    wr(ra(4, PMX_FLD_OD), 16'h0030, 2'b11, OK);
    pin(4, 16'h3f, 16'h0, 16'h3f, 16'h3f, 16'h0);
    $display("serial open-drain test done");
  endtask : t_serial

  task automatic t_two;
    logic [15:0] od_seen;
    wr(ra(2, PMX_FLD_FSEL), 16'hffff, 2'b10, OK);
    rdc(ra(2, PMX_FLD_FSEL), 32'h0300, OK);
    pin(2, 16'h33f, 16'h0, 16'h33f, 16'h300, 16'h0);
    // open-drain on the bus pins: a driven high releases the pin
    wr(ra(2, PMX_FLD_OD), 16'h0300, 2'b11, OK);
    repeat (3) @(posedge aclk);
    od_seen = pad_out[2].o | pad_out[2].oe;
    chk("two-wire", {16'h0, od_seen & 16'h0300}, 32'h0);
    wr(ra(2, PMX_FLD_FSEL), 16'hffff, 2'b01, OK);
    rdc(ra(2, PMX_FLD_FSEL), 32'h033f, OK);
    $display("two-wire and byte lane test done");
  endtask : t_two

  task automatic t_key;
    wr(ra(4, PMX_FLD_FSEL), 16'h0, 2'b11, OK);
    wr(ra(4, PMX_FLD_OD), 16'h0, 2'b11, OK);
    wr(12'h0a0, 16'h003f, 2'b11, OK);
    repeat (3) @(posedge aclk);
    chk("key", {26'h0, key}, {26'h0, EXT[5:0]});
    rdc(ra(4, PMX_FLD_LATCH), {16'h0, EXT & 16'h3f}, OK);
    $display("key-return test done");
  endtask : t_key

  task automatic t_misc;
    wr(ra(1, PMX_FLD_DIR), 16'h0, 2'b11, OK);
    repeat (3) @(posedge aclk);
    chk("analog", {30'h0, ana}, 32'h0);
    wr(ra(1, PMX_FLD_DIR), 16'h00ff, 2'b11, OK);
    repeat (3) @(posedge aclk);
    chk("analog", {30'h0, ana}, 32'h3);
    wr(12'h0a4, 16'hffff, 2'b11, OK);
    wr(12'h0a8, 16'h0014, 2'b11, OK);
    repeat (3) @(posedge aclk);
    chk("rise", {16'h0, rise}, 32'h7c);
    chk("fall", {16'h0, fall}, 32'h14);
    rdc(12'h0a4, 32'h7c, OK);
    $display("analog and edge test done");
  endtask : t_misc

  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    ext = EXT;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_port();
    t_func();
    t_choice();
    t_serial();
    t_two();
    t_key();
    t_misc();
    close_out();
  end
endmodule : port_alternate_function_mux_test
